// ===== design/embi_pkg.sv
// Package for the external memory bus interface: widths, encodings, carriers.
// Assumes a single 250 MHz clock domain; pins are resolved by the surroundings.
package embi_pkg;
  localparam int EMBI_AW = 24;
  localparam int EMBI_DW = 32;
  localparam logic [1:0] EMBI_W8 = 2'h0;
  localparam logic [1:0] EMBI_W16 = 2'h1;
  localparam logic [1:0] EMBI_W32 = 2'h2;
  // Reset widths of the two bank controls, chosen by the program-width pin
  localparam logic [1:0] EMBI_RST_W_NARROW = 2'h1;
  localparam logic [1:0] EMBI_RST_W_WIDE = 2'h2;
  localparam logic [3:0] EMBI_ALL_LANES = 4'hF;
  localparam logic [3:0] EMBI_NO_LANES = 4'h0;
  // Edges after reset release before the width pin has crossed its synchroniser
  localparam logic [1:0] EMBI_PW_SETTLE = 2'h2;
  // Ready samples ignored at the start of each bus cycle (pin, far side and synchroniser delay)
  localparam logic [2:0] EMBI_RDY_BLANK = 3'h4;

  typedef enum logic [1:0] {EMBI_SPACE_B0, EMBI_SPACE_B1, EMBI_SPACE_IO} embi_space_t;

  // Request from the processor core
  typedef struct packed {
    logic [EMBI_AW-1:0] addr;
    logic [EMBI_DW-1:0] wdata;
    logic [3:0] lanes;
    logic write;
    logic fetch;
    embi_space_t space;
  } embi_req_t;

  // Output pins of the bus other than data
  typedef struct packed {
    logic [EMBI_AW-1:0] addr;
    logic [3:0] bank0_strobe;
    logic [3:0] bank1_strobe;
    logic io_periph_strobe;
    logic read_not_write;
  } embi_pins_t;
endpackage

// ===== design/embi_sync.sv
// Two-flop synchroniser for pin inputs.
// Assumes the input is asynchronous to i_clock; the reset value is a constant.
`timescale 1ns/100ps
module embi_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_async,
  output logic o_sync
);
  logic meta_reg;

  // First stage is read only by the second stage
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_reg <= RST_VAL;
      o_sync <= RST_VAL;
    end else begin
      meta_reg <= i_async;
      o_sync <= meta_reg;
    end
  end
endmodule

// ===== design/embi_top.sv
// External memory bus interface: address, data, strobes, ready and bus release.
// Assumes core requests are synchronous; pins are resolved from enables outside.
// Summary of operation
// - Drive 24-bit address on every transaction.
// - 32-bit data bus, bidirectional by direction.
// - Direction high on reads, low on writes.
// - 32-bit bank: four strobes are lane enables.
// - 8/16-bit bank: lane-3 strobe becomes address.
// - 8-bit bank only: lane-2 strobe becomes address.
// - Separate peripheral strobe for I/O space.
// - Finish current transaction before releasing bus.
// - Float bus and suspend while release granted.
// - Grant low answers a low release request.
// - Grant high when request high or ignored.
// - Width low: fetch one 32-bit word.
// - Width high: two 16-bit fetches per instruction.
// - Width pin at reset seeds bank widths.
// - Float rules for global float and reset.
`timescale 1ns/100ps
module embi_top (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_req_valid,
  input wire embi_pkg::embi_req_t i_req,
  input wire logic [1:0] i_bank0_width,
  input wire logic [1:0] i_bank1_width,
  input wire logic i_width_load,
  input wire logic i_ignore_release_bit,
  output logic o_req_ready,
  output logic o_done,
  output logic [embi_pkg::EMBI_DW-1:0] o_rdata,
  output logic [1:0] o_bank0_width,
  output logic [1:0] o_bank1_width,
  input wire logic i_ready,
  input wire logic i_release_req_b,
  input wire logic i_global_float_request_b,
  input wire logic i_program_width_select,
  input wire logic [embi_pkg::EMBI_DW-1:0] i_ext_data_bus,
  output logic [embi_pkg::EMBI_DW-1:0] o_ext_data_bus,
  output logic o_ext_data_bus_oe,
  output embi_pkg::embi_pins_t o_pins,
  output logic o_addr_oe,
  output logic o_ctrl_oe,
  output logic o_bus_release_grant
);
  import embi_pkg::*;

  typedef enum logic [1:0] {EMBI_IDLE, EMBI_ACTIVE, EMBI_RELEASED} embi_state_t;

  embi_state_t state_reg;
  logic ready_s, rel_b_s, float_b_s, pw_s;
  logic pw_seen_reg;
  logic second_half_reg;
  embi_req_t cur_reg;
  logic [1:0] width_cur;
  logic release_wanted;
  logic [3:0] lanes_next;
  logic [EMBI_AW-1:0] addr_next;
  logic [1:0] pw_cnt_reg;
  logic [2:0] rdy_wait_reg;
  logic rdy_ok;

  embi_sync #(.RST_VAL(1'b0)) u_sync_rdy (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_async(i_ready), .o_sync(ready_s));
  embi_sync #(.RST_VAL(1'b1)) u_sync_rel (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_async(i_release_req_b),
    .o_sync(rel_b_s));
  embi_sync #(.RST_VAL(1'b1)) u_sync_flt (.i_clock(i_clock), .i_rst_b(i_rst_b),
    .i_async(i_global_float_request_b), .o_sync(float_b_s));
  embi_sync #(.RST_VAL(1'b0)) u_sync_pw (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_async(i_program_width_select),
    .o_sync(pw_s));

  // A request is ignored while the ignore bit is set
  assign release_wanted = !rel_b_s && !i_ignore_release_bit;
  // Program fetches use the pin width, data uses the bank width
  assign width_cur = cur_reg.fetch ? (pw_s ? EMBI_W16 : EMBI_W32) :
    (cur_reg.space == EMBI_SPACE_B1 ? o_bank1_width : o_bank0_width);

  // A high ready early in a bus cycle still belongs to the previous one:
  // strobe register and far side each add an edge of delay, the synchroniser two
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdy_wait_reg <= 3'h0;
    end else if (state_reg != EMBI_ACTIVE || rdy_ok) begin
      rdy_wait_reg <= 3'h0;
    end else if (rdy_wait_reg != EMBI_RDY_BLANK) begin
      rdy_wait_reg <= rdy_wait_reg + 3'h1;
    end
  end
  assign rdy_ok = ready_s && rdy_wait_reg == EMBI_RDY_BLANK;

  // Width pin caught once after reset release, only when the synchroniser holds the pin
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pw_seen_reg <= 1'b0;
      pw_cnt_reg <= 2'h0;
      o_bank0_width <= EMBI_RST_W_WIDE;
      o_bank1_width <= EMBI_RST_W_WIDE;
    end else if (!pw_seen_reg && pw_cnt_reg != EMBI_PW_SETTLE) begin
      pw_cnt_reg <= pw_cnt_reg + 2'h1; // Synchroniser output is still its reset value
    end else if (!pw_seen_reg) begin
      pw_seen_reg <= 1'b1;
      o_bank0_width <= pw_s ? EMBI_RST_W_NARROW : EMBI_RST_W_WIDE;
      o_bank1_width <= pw_s ? EMBI_RST_W_NARROW : EMBI_RST_W_WIDE;
    end else if (i_width_load) begin
      o_bank0_width <= i_bank0_width;
      o_bank1_width <= i_bank1_width;
    end
  end

  // Transaction sequencer; release only taken from idle so a cycle always ends
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg <= EMBI_IDLE;
      cur_reg <= '0;
      second_half_reg <= 1'b0;
      o_done <= 1'b0;
      o_rdata <= '0;
    end else begin
      o_done <= 1'b0;
      case (state_reg)
        EMBI_IDLE: begin
          if (release_wanted) begin
            state_reg <= EMBI_RELEASED;
          end else if (i_req_valid && pw_seen_reg) begin
            cur_reg <= i_req;
            second_half_reg <= 1'b0;
            state_reg <= EMBI_ACTIVE;
          end
        end
        EMBI_ACTIVE: begin
          // Strobe stays until ready is seen; slow parts add waits
          if (rdy_ok) begin
            if (!cur_reg.write) begin
              if (cur_reg.fetch && width_cur == EMBI_W16) begin
                if (second_half_reg) o_rdata[31:16] <= i_ext_data_bus[15:0];
                else o_rdata[15:0] <= i_ext_data_bus[15:0];
              end else begin
                o_rdata <= i_ext_data_bus;
              end
            end
            if (cur_reg.fetch && width_cur == EMBI_W16 && !second_half_reg) begin
              second_half_reg <= 1'b1;
            end else begin
              o_done <= 1'b1;
              state_reg <= EMBI_IDLE;
            end
          end
        end
        EMBI_RELEASED: begin
          if (!release_wanted) state_reg <= EMBI_IDLE;
        end
        default: state_reg <= EMBI_IDLE;
      endcase
    end
  end

  // Narrow banks put low address bits on the upper strobe lines
  always_comb begin
    lanes_next = cur_reg.lanes;
    addr_next = cur_reg.addr;
    if (cur_reg.fetch && width_cur == EMBI_W16) begin
      addr_next = {cur_reg.addr[EMBI_AW-2:0], second_half_reg};
    end
    if (width_cur == EMBI_W16) begin
      lanes_next = {addr_next[0], 1'b0, 2'h3};
    end else if (width_cur == EMBI_W8) begin
      lanes_next = {addr_next[0], addr_next[1], 2'h1};
    end
  end

  // Pin registers; strobes are active high here (asserted lanes)
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pins <= '0;
      o_ext_data_bus <= '0;
    end else begin
      o_pins.addr <= addr_next;
      o_pins.read_not_write <= !(state_reg == EMBI_ACTIVE && cur_reg.write);
      o_ext_data_bus <= cur_reg.wdata;
      o_pins.bank0_strobe <= (state_reg == EMBI_ACTIVE && cur_reg.space == EMBI_SPACE_B0) ? lanes_next : EMBI_NO_LANES;
      o_pins.bank1_strobe <= (state_reg == EMBI_ACTIVE && cur_reg.space == EMBI_SPACE_B1) ? lanes_next : EMBI_NO_LANES;
      o_pins.io_periph_strobe <= state_reg == EMBI_ACTIVE && cur_reg.space == EMBI_SPACE_IO;
    end
  end

  // Output enables and grant; reset floats address and data only
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_addr_oe <= 1'b0;
      o_ctrl_oe <= 1'b1;
      o_ext_data_bus_oe <= 1'b0;
      o_bus_release_grant <= 1'b1;
      o_req_ready <= 1'b0;
    end else begin
      o_addr_oe <= float_b_s && state_reg != EMBI_RELEASED;
      o_ctrl_oe <= float_b_s && state_reg != EMBI_RELEASED;
      o_ext_data_bus_oe <= float_b_s && state_reg == EMBI_ACTIVE && cur_reg.write;
      o_bus_release_grant <= !(state_reg == EMBI_RELEASED && release_wanted);
      o_req_ready <= state_reg == EMBI_IDLE && !release_wanted && pw_seen_reg;
    end
  end

  // Grant may only fall while no strobe is active
  a_grant_idle: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    $fell(o_bus_release_grant) |-> !o_pins.io_periph_strobe && o_pins.bank0_strobe == EMBI_NO_LANES &&
    o_pins.bank1_strobe == EMBI_NO_LANES)
    else $error("grant fell during transaction");
  a_release_float: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    !o_bus_release_grant |-> !o_addr_oe && !o_ctrl_oe && !o_ext_data_bus_oe)
    else $error("bus driven while released");
  a_grant_high: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (i_ignore_release_bit ##1 1'b1) |-> o_bus_release_grant)
    else $error("grant low while ignored");
  a_float_pin: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    !float_b_s |=> !o_addr_oe && !o_ctrl_oe)
    else $error("global float ignored");
  a_dir_write: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    o_ext_data_bus_oe |-> !o_pins.read_not_write)
    else $error("data driven on read");
  a_io_excl: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    o_pins.io_periph_strobe |-> o_pins.bank0_strobe == EMBI_NO_LANES && o_pins.bank1_strobe == EMBI_NO_LANES)
    else $error("io strobe with bank strobe");
  a_wait_ready: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (state_reg == EMBI_ACTIVE && !ready_s) |=> state_reg == EMBI_ACTIVE)
    else $error("cycle ended without ready");
  a_ready_blank: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (state_reg == EMBI_ACTIVE && rdy_wait_reg != EMBI_RDY_BLANK) |=> state_reg == EMBI_ACTIVE)
    else $error("stale ready ended cycle");
  a_grant_low: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (state_reg == EMBI_IDLE && release_wanted ##1 release_wanted) |-> ##1 !o_bus_release_grant)
    else $error("no grant for request");
  a_narrow_lane2: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (state_reg == EMBI_ACTIVE && cur_reg.space == EMBI_SPACE_B0 && width_cur == EMBI_W16) |=> !o_pins.bank0_strobe[2])
    else $error("lane2 used as address at 16 bit");
endmodule

// ===== tb/embi_mem_model.sv
// Partner model: external memory or peripheral on the far side of the bus.
// Assumes the bench resolves the data wire from the design's output enable.
`timescale 1ns/100ps
module embi_mem_model (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire embi_pkg::embi_pins_t i_pins,
  input wire logic i_ctrl_oe,
  input wire logic signed [31:0] i_delay,
  output logic o_ready,
  output logic [embi_pkg::EMBI_DW-1:0] o_data
);
  import embi_pkg::*;
  logic active;
  logic [EMBI_AW-1:0] addr_reg;
  logic [EMBI_DW-1:0] last_reg;
  int cnt_reg;
  // Any strobe bit counts; in narrow modes bit 0 stays high as the select
  assign active = i_ctrl_oe && ((|i_pins.bank0_strobe) || (|i_pins.bank1_strobe) || i_pins.io_periph_strobe);
  // Inverse of the last value when not read, so a stale bus never matches
  assign o_data = (active && i_pins.read_not_write) ? {8'hA5, i_pins.addr} : ~last_reg;
  // Ready only after the wait count, dropped on a new address or idle
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_reg <= 0;
      o_ready <= 1'b0;
      addr_reg <= '0;
      last_reg <= '0;
    end else if (!active || i_pins.addr != addr_reg) begin
      cnt_reg <= 0;
      o_ready <= 1'b0;
      addr_reg <= i_pins.addr;
    end else begin
      last_reg <= o_data;
      if (cnt_reg >= i_delay) o_ready <= 1'b1;
      else cnt_reg <= cnt_reg + 1;
    end
  end
endmodule

// ===== tb/test_external_memory_bus_interface.sv
// Self-checking bench for the external memory bus interface.
// Assumes one 250 MHz clock; the partner model answers each strobe.
`timescale 1ns/100ps
module test_external_memory_bus_interface;
  import embi_pkg::*;
  logic clk = 0, rst_b = 0, valid = 0, wload = 0, ign = 0, rel_b = 1, flt_b = 1, pw = 0;
  logic [1:0] w0 = EMBI_W32, w1 = EMBI_W32;
  embi_req_t req = '0;
  int dly = 0, failures = 0, n_checks = 0, cyc = 0;
  logic done, rdy_o, doe, aoe, coe, grant, mrdy, wdoe;
  logic [1:0] bw0, bw1;
  logic [31:0] rdata, dout, din, mdata, wdat;
  logic [23:0] last_a;
  embi_pins_t pins, snap;
  always #2 clk = ~clk;
  // Wire level: design drives on writes, partner otherwise
  assign din = doe ? dout : mdata;
  embi_top embi_top_inst (.i_clock(clk), .i_rst_b(rst_b), .i_req_valid(valid), .i_req(req),
    .i_bank0_width(w0), .i_bank1_width(w1), .i_width_load(wload), .i_ignore_release_bit(ign),
    .o_req_ready(rdy_o), .o_done(done), .o_rdata(rdata), .o_bank0_width(bw0), .o_bank1_width(bw1),
    .i_ready(mrdy), .i_release_req_b(rel_b), .i_global_float_request_b(flt_b),
    .i_program_width_select(pw), .i_ext_data_bus(din), .o_ext_data_bus(dout),
    .o_ext_data_bus_oe(doe), .o_pins(pins), .o_addr_oe(aoe), .o_ctrl_oe(coe),
    .o_bus_release_grant(grant));
  embi_mem_model embi_mem_model_inst (.i_clock(clk), .i_rst_b(rst_b), .i_pins(pins),
    .i_ctrl_oe(coe), .i_delay(dly), .o_ready(mrdy), .o_data(mdata));
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    n_checks++;
    if (s !== e) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic results();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  task automatic settle();
    for (int n = 0; n < 30 && rdy_o !== 1'b1; n++) step();
  endtask
  // Reset with a given width pin; outputs are checked while reset holds
  task automatic do_reset(input logic p);
    pw = p;
    rst_b = 1'b0;
    repeat (10) step();
    chk({aoe, doe, coe, grant, done}, 5'h06);
    rst_b = 1'b1;
    settle();
    chk({bw0, bw1}, p ? {EMBI_RST_W_NARROW, EMBI_RST_W_NARROW} : {EMBI_RST_W_WIDE, EMBI_RST_W_WIDE});
  endtask
  // One request; the first active cycle of the pins is kept for judging
  task automatic xfer(input embi_req_t r, input int d);
    int n;
    n = 0;
    dly = d;
    req = r;
    valid = 1'b1;
    snap = '0;
    while (rdy_o !== 1'b1 && n < 50) begin
      step();
      n++;
    end
    @(posedge clk);
    #1 valid = 1'b0;
    while (done !== 1'b1 && n < 200) begin
      if (coe === 1'b1 && (|pins.bank0_strobe || |pins.bank1_strobe || pins.io_periph_strobe)) begin
        if (snap === '0) {snap, wdoe, wdat} = {pins, doe, dout};
        last_a = pins.addr;
      end
      step();
      n++;
    end
    chk(n < 200, 1);
  endtask
  task automatic t_wide();
    xfer('{24'h12345C, 32'hCAFE0123, 4'h6, 1'b1, 1'b0, EMBI_SPACE_B0}, 1);
    chk(snap.addr, 24'h12345C);
    chk({snap.bank0_strobe, snap.bank1_strobe, snap.io_periph_strobe}, 9'h0C0);
    chk({snap.read_not_write, wdoe, wdat}, {2'h1, 32'hCAFE0123});
    xfer('{24'hABCDE0, 32'h0, 4'hF, 1'b0, 1'b0, EMBI_SPACE_B1}, 5);
    chk({snap.read_not_write, snap.bank1_strobe}, 5'h1F);
    chk(rdata, 32'hA5ABCDE0);
    xfer('{24'h000100, 32'h0, 4'hF, 1'b0, 1'b0, EMBI_SPACE_IO}, 0);
    chk({snap.io_periph_strobe, snap.bank0_strobe, snap.bank1_strobe}, 9'h100);
    $display("test wide done");
  endtask
  // Both narrow widths, all four low address combinations
  task automatic t_narrow();
    logic [1:0] w;
    for (int i = 0; i < 8; i++) begin
      w = (i < 4) ? EMBI_W8 : EMBI_W16;
      w0 = w;
      wload = 1'b1;
      step();
      wload = 1'b0;
      step();
      chk(bw0, w);
      xfer('{24'h000040 | i[1:0], 32'h0, 4'hF, 1'b0, 1'b0, EMBI_SPACE_B0}, 0);
      chk(snap.bank0_strobe, (w == EMBI_W8) ? {i[0], i[1], 2'h1} : {i[0], 3'h3});
    end
    w0 = EMBI_W32;
    $display("test narrow done");
  endtask
  task automatic t_fetch();
    do_reset(1'b1);
    xfer('{24'h000321, 32'h0, 4'hF, 1'b0, 1'b1, EMBI_SPACE_B0}, 2);
    chk({snap.addr, last_a}, {24'h000642, 24'h000643});
    chk(rdata, 32'h06430642);
    do_reset(1'b0);
    xfer('{24'h000321, 32'h0, 4'hF, 1'b0, 1'b1, EMBI_SPACE_B0}, 2);
    chk(rdata, 32'hA5000321);
    $display("test fetch done");
  endtask
  task automatic t_release();
    fork
      xfer('{24'h000777, 32'h0, 4'hF, 1'b0, 1'b0, EMBI_SPACE_B1}, 6);
      begin
        repeat (3) step();
        rel_b = 1'b0;
      end
    join
    chk({rdata, grant}, {32'hA5000777, 1'b1});
    repeat (8) step();
    chk({grant, aoe, coe, doe, rdy_o}, 5'h00);
    ign = 1'b1;
    repeat (8) step();
    chk(grant, 1'b1);
    rel_b = 1'b1;
    repeat (4) step(); // Request must read high past the synchroniser before the ignore bit drops
    ign = 1'b0;
    settle();
    chk(grant, 1'b1);
    flt_b = 1'b0;
    repeat (8) step();
    chk({aoe, coe, doe}, 3'h0);
    flt_b = 1'b1;
    settle();
    $display("test release done");
  endtask
  // Cycle ceiling cuts a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      results();
    end
  end
  initial begin
    #1;
    do_reset(1'b0);
    t_wide();
    t_narrow();
    t_fetch();
    t_release();
    results();
  end
endmodule
